// ==== src/pwsh_pkg.sv ====
// What this block does
// - Frames may span many payloads; reassemble them
// - Tell frame segments from message block segments
// - One table entry per payload segment
// - Entries are 32 bits with channel, sequence, profile
// - Check header sequence only when flagged valid
// - Demultiplex payloads by three-bit flow selector
// - Reserved header bit is ignored on receive
// - Segment count equals number of table entries
// - Header sequence gaps reveal lost packets
// - Frame segment begin flag marks frame start
// - Message begin flag means 32-bit timestamp precedes
// - End flag marks frame end; ignored for messages
// - Fourteen-bit length locates each segment boundary
// - Eight-bit channel selector in every entry
// - Profile low bit on link channel marks kind
package pwsh_pkg;
	localparam int HDR_BYTES     = 4;
	localparam int ENTRY_BYTES   = 4;
	localparam int TS_BYTES      = 4;
	localparam int MAX_SEGS      = 128;
	localparam int NUM_FLOWS     = 8;
	localparam int NUM_CHANS     = 256;
	localparam int PROF_TYPE_BIT = 0;
	localparam int BUF_DEPTH     = 2;

	// Sublayer header, most significant bit first as it arrives on the wire.
	typedef struct packed {
		logic        vccv;
		logic        seq_ok;
		logic [1:0]  ext_hdr;
		logic [2:0]  flow_selector;
		logic        rsvd_x;
		logic        rsvd_pad;
		logic [6:0]  seg_count;
		logic [15:0] seq_num;
	} pwsh_hdr_t;

	// One segment table entry, also most significant bit first.
	typedef struct packed {
		logic        begin_f;
		logic        end_f;
		logic [13:0] seg_len;
		logic [7:0]  channel_selector;
		logic [3:0]  chan_seq;
		logic [3:0]  modulation_profile;
	} pwsh_entry_t;

	// One delivered payload byte with its reassembly tags.
	typedef struct packed {
		logic [7:0] data;
		logic [2:0] flow_selector;
		logic [7:0] channel_selector;
		logic       is_msg_block;
		logic       is_timestamp;
		logic       frame_first;
		logic       frame_last;
		logic [3:0] modulation_profile;
	} pwsh_byte_t;

	typedef enum logic [1:0] {
		ST_HDR   = 2'h0,
		ST_TBL   = 2'h1,
		ST_PAY   = 2'h2,
		ST_DRAIN = 2'h3
	} pwsh_state_t;
endpackage

// ==== src/pwsh_rx.sv ====
`timescale 1ns/1ps
module pwsh_rx (
	input  wire logic                CLK_I,                // Packet clock, 40 MHz.
	input  wire logic                RESET_I,              // Synchronous reset, high.
	input  wire logic                IN_VALID_I,           // Payload byte valid.
	input  wire logic [7:0]          IN_DATA_I,            // Payload byte.
	input  wire logic                IN_LAST_I,            // Last byte of the packet.
	output logic                     IN_READY_O,           // Byte accepted.
	input  wire logic [7:0]          LINK_SUB_CHANNEL_I,   // Channel used as link sub-channel.
	input  wire logic                LINK_SUB_CHANNEL_EN_I, // Link sub-channel present.
	output logic                     OUT_VALID_O,          // Reassembled byte valid.
	input  wire logic                OUT_READY_I,          // Receiver takes the byte.
	output pwsh_pkg::pwsh_byte_t     OUT_DATA_O,           // Byte and its tags.
	output logic                     LOSS_PKT_O,           // Header sequence gap, pulse.
	output logic                     LOSS_SEG_O            // Channel sequence gap, pulse.
);
	import pwsh_pkg::*;

	pwsh_state_t                 state_r, state_nxt;
	logic [1:0]                  cnt_r, cnt_nxt;
	logic [23:0]                 shift_r, shift_nxt;
	pwsh_hdr_t                   hdr_r, hdr_nxt;
	logic [6:0]                  seg_idx_r, seg_idx_nxt;
	logic [13:0]                 pos_r, pos_nxt;
	logic                        keep_r, keep_nxt;
	logic [15:0]                 exp_seq_r [NUM_FLOWS], exp_seq_nxt [NUM_FLOWS];
	logic [NUM_FLOWS-1:0]        seq_vld_r, seq_vld_nxt;
	logic [NUM_CHANS-1:0]        in_frame_r, in_frame_nxt;
	logic [3:0]                  chseq_r [NUM_CHANS], chseq_nxt [NUM_CHANS];
	logic [NUM_CHANS-1:0]        chvld_r, chvld_nxt;
	logic                        loss_pkt_r, loss_pkt_nxt;
	logic                        loss_seg_r, loss_seg_nxt;
	pwsh_entry_t                 tbl_mem [MAX_SEGS];
	logic                        tbl_we;
	pwsh_byte_t                  buf_mem_r [BUF_DEPTH];
	logic                        buf_wp_r, buf_rp_r;
	logic [1:0]                  buf_cnt_r;
	logic [31:0]                 word;
	pwsh_hdr_t                   hdr_w;
	pwsh_entry_t                 cur;
	logic                        take, first, last, last_seg, is_msg, gap, open_f, keep, push;
	logic                        pop, buf_full;
	logic [7:0]                  ch;
	pwsh_byte_t                  wr_byte;

	// Segment view: the stored entry, its kind and its byte position.
	always_comb begin
		word     = {shift_r, IN_DATA_I};
		hdr_w    = pwsh_hdr_t'(word);
		cur      = tbl_mem[seg_idx_r];
		ch       = cur.channel_selector;
		is_msg   = LINK_SUB_CHANNEL_EN_I && (ch == LINK_SUB_CHANNEL_I)
			&& cur.modulation_profile[PROF_TYPE_BIT];
		first    = (pos_r == 14'h0000);
		last     = (pos_r == cur.seg_len - 14'h0001);
		last_seg = (seg_idx_r == hdr_r.seg_count - 7'h01);
		buf_full = (buf_cnt_r == 2'(BUF_DEPTH));
		if (state_r == ST_PAY) begin
			IN_READY_O = !buf_full && (cur.seg_len != 14'h0000);
		end else begin
			IN_READY_O = 1'b1;
		end
		take   = IN_VALID_I && IN_READY_O;
		gap    = chvld_r[ch] && (cur.chan_seq != chseq_r[ch]);
		open_f = in_frame_r[ch] && !gap;
		keep   = first ? (is_msg || cur.begin_f || open_f) : keep_r;
		push   = (state_r == ST_PAY) && take && keep;
		pop    = OUT_VALID_O && OUT_READY_I;
		wr_byte.data               = IN_DATA_I;
		wr_byte.flow_selector      = hdr_r.flow_selector;
		wr_byte.channel_selector   = ch;
		wr_byte.is_msg_block       = is_msg;
		wr_byte.is_timestamp       = is_msg && cur.begin_f && (pos_r < 14'(TS_BYTES));
		wr_byte.frame_first        = first && (is_msg || cur.begin_f);
		wr_byte.frame_last         = last && (is_msg || cur.end_f);
		wr_byte.modulation_profile = (first && !is_msg && cur.begin_f)
			? cur.modulation_profile : 4'h0;
	end

	// Parser and reassembly state: header, table, payload, tail drain.
	always_comb begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		shift_nxt    = shift_r;
		hdr_nxt      = hdr_r;
		seg_idx_nxt  = seg_idx_r;
		pos_nxt      = pos_r;
		keep_nxt     = keep_r;
		exp_seq_nxt  = exp_seq_r;
		seq_vld_nxt  = seq_vld_r;
		in_frame_nxt = in_frame_r;
		chseq_nxt    = chseq_r;
		chvld_nxt    = chvld_r;
		loss_pkt_nxt = 1'b0;
		loss_seg_nxt = 1'b0;
		tbl_we       = 1'b0;
		if (take) begin
			shift_nxt = word[23:0];
		end
		case (state_r)
			ST_HDR: begin
				if (take) begin
					cnt_nxt = cnt_r + 2'h1;
					if (cnt_r == 2'(HDR_BYTES - 1)) begin
						hdr_nxt     = hdr_w;
						seg_idx_nxt = 7'h00;
						if (hdr_w.seq_ok) begin
							if (seq_vld_r[hdr_w.flow_selector] && (hdr_w.seq_num
								!= exp_seq_r[hdr_w.flow_selector])) begin
								loss_pkt_nxt = 1'b1;
								in_frame_nxt = '0;
							end
							exp_seq_nxt[hdr_w.flow_selector] = hdr_w.seq_num + 16'h0001;
							seq_vld_nxt[hdr_w.flow_selector] = 1'b1;
						end
						if (IN_LAST_I) begin
							state_nxt = ST_HDR;
						end else if (hdr_w.seg_count == 7'h00) begin
							state_nxt = ST_DRAIN;
						end else begin
							state_nxt = ST_TBL;
						end
					end
					if (IN_LAST_I) begin
						cnt_nxt = 2'h0;
					end
				end
			end
			ST_TBL: begin
				if (take) begin
					cnt_nxt = cnt_r + 2'h1;
					if (cnt_r == 2'(ENTRY_BYTES - 1)) begin
						tbl_we      = 1'b1;
						seg_idx_nxt = seg_idx_r + 7'h01;
						if (last_seg) begin
							seg_idx_nxt = 7'h00;
							pos_nxt     = 14'h0000;
							state_nxt   = ST_PAY;
						end
					end
					if (IN_LAST_I) begin
						cnt_nxt   = 2'h0;
						state_nxt = ST_HDR;
					end
				end
			end
			ST_PAY: begin
				if (cur.seg_len == 14'h0000) begin
					seg_idx_nxt = seg_idx_r + 7'h01;
					state_nxt   = last_seg ? ST_DRAIN : ST_PAY;
				end else if (take) begin
					pos_nxt  = pos_r + 14'h0001;
					keep_nxt = keep;
					if (first) begin
						loss_seg_nxt   = gap;
						chvld_nxt[ch]  = 1'b1;
						chseq_nxt[ch]  = cur.chan_seq + 4'h1;
						if (!is_msg) begin
							in_frame_nxt[ch] = cur.begin_f || open_f;
						end
					end
					if (last) begin
						pos_nxt     = 14'h0000;
						seg_idx_nxt = seg_idx_r + 7'h01;
						if (!is_msg && cur.end_f) begin
							in_frame_nxt[ch] = 1'b0;
						end
						if (last_seg) begin
							state_nxt = ST_DRAIN;
						end
					end
					if (IN_LAST_I) begin
						state_nxt = ST_HDR;
						cnt_nxt   = 2'h0;
						if (!(last && last_seg)) begin
							in_frame_nxt[ch] = 1'b0;
						end
					end
				end
			end
			ST_DRAIN: begin
				if (take && IN_LAST_I) begin
					state_nxt = ST_HDR;
					cnt_nxt   = 2'h0;
				end
			end
			default: begin
				state_nxt = ST_HDR;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state_r    <= ST_HDR;
			cnt_r      <= 2'h0;
			shift_r    <= 24'h00_0000;
			hdr_r      <= '0;
			seg_idx_r  <= 7'h00;
			pos_r      <= 14'h0000;
			keep_r     <= 1'b0;
			exp_seq_r  <= '{default: 16'h0000};
			seq_vld_r  <= '0;
			in_frame_r <= '0;
			chseq_r    <= '{default: 4'h0};
			chvld_r    <= '0;
			loss_pkt_r <= 1'b0;
			loss_seg_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			shift_r    <= shift_nxt;
			hdr_r      <= hdr_nxt;
			seg_idx_r  <= seg_idx_nxt;
			pos_r      <= pos_nxt;
			keep_r     <= keep_nxt;
			exp_seq_r  <= exp_seq_nxt;
			seq_vld_r  <= seq_vld_nxt;
			in_frame_r <= in_frame_nxt;
			chseq_r    <= chseq_nxt;
			chvld_r    <= chvld_nxt;
			loss_pkt_r <= loss_pkt_nxt;
			loss_seg_r <= loss_seg_nxt;
		end
	end

	// Segment table store; contents need no reset as the count guards reads.
	always_ff @(posedge CLK_I) begin
		if (tbl_we) begin
			tbl_mem[seg_idx_r] <= pwsh_entry_t'(word);
		end
	end

	// Two-entry output buffer; when full it stalls the payload input.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			buf_wp_r  <= 1'b0;
			buf_rp_r  <= 1'b0;
			buf_cnt_r <= 2'h0;
			buf_mem_r <= '{default: '0};
		end else begin
			if (push) begin
				buf_mem_r[buf_wp_r] <= wr_byte;
				buf_wp_r            <= !buf_wp_r;
			end
			if (pop) begin
				buf_rp_r <= !buf_rp_r;
			end
			buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	assign OUT_VALID_O = (buf_cnt_r != 2'h0);
	assign OUT_DATA_O  = buf_mem_r[buf_rp_r];
	assign LOSS_PKT_O  = loss_pkt_r;
	assign LOSS_SEG_O  = loss_seg_r;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_hdr_done;
		(state_r == ST_HDR) && take && (cnt_r == 2'h3) && !IN_LAST_I;
	endsequence
	sequence s_last_byte;
		(state_r == ST_PAY) && take && last && last_seg && !IN_LAST_I;
	endsequence

	chk_table_follows: assert property (s_hdr_done ##0 (hdr_w.seg_count != 7'h00)
		|=> (state_r == ST_TBL) && (seg_idx_r == 7'h00)) else $error("table not entered");
	chk_payload_ends: assert property (s_last_byte |=> (state_r == ST_DRAIN))
		else $error("payload did not end after last segment");
	chk_seq_unflagged: assert property ((state_r == ST_HDR) && take && (cnt_r == 2'h3)
		&& !hdr_w.seq_ok |=> !LOSS_PKT_O) else $error("unflagged sequence checked");
	chk_loss_clears: assert property (LOSS_PKT_O |-> (in_frame_r == '0))
		else $error("partial frame kept after loss");
	chk_ts_bytes: assert property (push && wr_byte.is_timestamp
		|-> is_msg && cur.begin_f && (pos_r <= 14'h0003)) else $error("bad timestamp tag");
	chk_msg_end_flag: assert property (push && is_msg && !last |-> !wr_byte.frame_last)
		else $error("end flag honoured for message");
	chk_orphan_drop: assert property ((state_r == ST_PAY) && take && first && !is_msg
		&& !cur.begin_f && !open_f |-> !push) else $error("orphan segment passed");
	chk_flow_tag: assert property (push |=> (buf_mem_r[$past(buf_wp_r)].flow_selector
		== hdr_r.flow_selector)) else $error("wrong flow tag");
	chk_buf_hold: assert property (OUT_VALID_O && !OUT_READY_I
		|=> OUT_VALID_O && $stable(OUT_DATA_O)) else $error("stalled byte changed");
	chk_full_stall: assert property ((state_r == ST_PAY) && buf_full |-> !IN_READY_O)
		else $error("input taken while buffer full");
endmodule

// ==== verif/pwsh_src.sv ====
`timescale 1ns/1ps
module pwsh_src
	import pwsh_pkg::*;
(
	input  wire logic       clk_i,   // Packet clock.
	input  wire logic       ready_i, // Receiver takes the byte.
	output logic            valid_o, // Byte valid.
	output logic [7:0]      data_o,  // Payload byte.
	output logic            last_o   // Last byte of the packet.
);
	logic [15:0] seq_r [NUM_FLOWS];
	logic [3:0]  cs_r [NUM_CHANS];
	logic [7:0]  q [$];

	// Header sequences start from an arbitrary value; channel sequences start from zero.
	initial begin
		foreach (seq_r[i]) seq_r[i] = 16'hA5C3;
		foreach (cs_r[i]) cs_r[i] = 4'h0;
		valid_o = 1'b0;
		data_o = 8'h00;
		last_o = 1'b0;
	end

	// Frames one packet, then hands it over a byte at a time under the handshake.
	task automatic send(input logic s, input logic [2:0] f, input int g, input int cg,
		input pwsh_entry_t e[$], input logic [7:0] p[$], output bit ok);
		pwsh_hdr_t h;
		int n;
		h = '0;
		h.seq_ok = s;
		h.flow_selector = f;
		h.seg_count = 7'(e.size());
		h.seq_num = seq_r[f];
		seq_r[f] = seq_r[f] + 16'(1 + g);
		q = {h[31:24], h[23:16], h[15:8], h[7:0]};
		foreach (e[i]) begin
			cs_r[e[i].channel_selector] += 4'(cg);
			e[i].chan_seq = cs_r[e[i].channel_selector];
			cs_r[e[i].channel_selector] += 4'h1;
			q = {q, e[i][31:24], e[i][23:16], e[i][15:8], e[i][7:0]};
		end
		q = {q, p};
		ok = 1'b1;
		foreach (q[i]) begin
			valid_o = 1'b1;
			data_o = q[i];
			last_o = i == q.size() - 1;
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (!ready_i && n < 200);
			ok &= ready_i;
			#1;
			if (!ok) break;
		end
		valid_o = 1'b0;
		last_o = 1'b0;
		data_o = ~data_o;
		// One idle edge, so that the next packet never raises valid in this same step.
		@(posedge clk_i);
		#1;
	endtask
endmodule

// ==== verif/test_pseudowire_segment_header_codec.sv ====
`timescale 1ns/1ps
module test_pseudowire_segment_header_codec;
	import pwsh_pkg::*;
	typedef struct {logic k, b, e; logic [7:0] c; logic [3:0] p; int n; logic [2:0] f;
		logic m, ff, fe;} pwsh_row_t;
	logic       clk, rst, iv, il, ir, ov, ordy, hold, en, lp, ls;
	logic [7:0] id, pb = 8'h40;
	pwsh_byte_t od;
	pwsh_byte_t xq [$];
	int         fails, comparisons, npk, nsg, t = 0;
	// Keep, begin, end, channel, profile, length, flow; then kind and frame brackets.
	pwsh_row_t rows [8] = '{
		'{1, 1, 1, 8'h05, 4'h0, 3, 3'h1, 0, 1, 1},
		'{1, 1, 0, 8'h05, 4'h3, 2, 3'h1, 0, 1, 0},
		'{1, 0, 0, 8'h05, 4'h0, 2, 3'h1, 0, 0, 0},
		'{1, 0, 1, 8'h05, 4'h0, 2, 3'h1, 0, 0, 1},
		'{0, 0, 1, 8'h05, 4'h0, 2, 3'h0, 0, 0, 0},
		'{1, 1, 0, 8'h09, 4'h1, 6, 3'h2, 1, 1, 1},
		'{1, 0, 0, 8'h09, 4'h1, 3, 3'h2, 1, 1, 1},
		'{1, 1, 1, 8'h09, 4'h0, 2, 3'h3, 0, 1, 1}
	};

	pwsh_rx u_dut (.CLK_I(clk), .RESET_I(rst), .IN_VALID_I(iv), .IN_DATA_I(id),
		.IN_LAST_I(il), .IN_READY_O(ir), .LINK_SUB_CHANNEL_I(8'h09),
		.LINK_SUB_CHANNEL_EN_I(en), .OUT_VALID_O(ov), .OUT_READY_I(ordy),
		.OUT_DATA_O(od), .LOSS_PKT_O(lp), .LOSS_SEG_O(ls));
	pwsh_src u_src (.clk_i(clk), .ready_i(ir), .valid_o(iv), .data_o(id), .last_o(il));

	// Clock at 40 MHz.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// The receiver takes two bytes of every three unless held off.
	always @(posedge clk) begin
		t <= t + 1;
		ordy <= #1 !hold && (t % 3 != 0);
	end

	// Each delivered byte is compared with the oldest expected one; loss pulses are counted.
	always @(posedge clk) begin
		if (!rst && ov === 1'b1 && ordy === 1'b1) begin
			comparisons++;
			if (xq.size() == 0 || od !== xq[0]) begin
				fails++;
				$display("[ERR] %0t unexpected output byte %h", $time, od);
			end
			if (xq.size() != 0) void'(xq.pop_front());
		end
		if (lp === 1'b1) npk++;
		if (ls === 1'b1) nsg++;
	end

	task automatic check(input logic got, input logic want, input string w);
		comparisons++;
		if (got !== want) begin
			fails++;
			$display("[ERR] %0t %s", $time, w);
		end
	endtask

	task automatic give_verdict();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Sends one packet of segments and queues the bytes the receiver should deliver.
	task automatic run(input pwsh_row_t r[$], input logic s, input int g, input int cg);
		pwsh_entry_t e[$];
		logic [7:0]  p[$];
		pwsh_byte_t  x;
		bit          ok;
		foreach (r[j]) begin
			e.push_back({r[j].b, r[j].e, 14'(r[j].n), r[j].c, 4'h0, r[j].p});
			for (int i = 0; i < r[j].n; i++) begin
				x = '0;
				x.data = pb;
				x.flow_selector = r[0].f;
				x.channel_selector = r[j].c;
				x.is_msg_block = r[j].m;
				x.is_timestamp = r[j].m && r[j].b && i < TS_BYTES;
				x.frame_first = r[j].ff && i == 0;
				x.frame_last = r[j].fe && i == r[j].n - 1;
				x.modulation_profile = (x.frame_first && !r[j].m) ? r[j].p : 4'h0;
				p.push_back(pb);
				pb++;
				if (r[j].k) xq.push_back(x);
			end
		end
		u_src.send(s, r[0].f, g, cg, e, p, ok);
		check(ok, 1'b1, "input stalled");
		if (!ok) give_verdict();
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (xq.size() != 0 && n < 500) begin
			@(posedge clk);
			n++;
		end
		#1;
		check(xq.size() == 0, 1'b1, "output bytes missing");
		if (xq.size() != 0) give_verdict();
	endtask

	// Reset, the ordinary rows, then the awkward cases.
	initial begin
		rst = 1'b1;
		hold = 1'b0;
		en = 1'b1;
		ordy = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(ir, 1'b1, "not ready in reset");
		check(ov | lp | ls, 1'b0, "output active in reset");
		check(od === '0, 1'b1, "output data not clear in reset");
		rst = 1'b0;
		foreach (rows[i]) run({rows[i]}, 1'b1, 0, 0);
		drain();
		check(npk + nsg == 0, 1'b1, "false loss report");
		// Two segments in one packet while the receiver is held off.
		hold = 1'b1;
		fork
			run({rows[0], rows[5]}, 1'b1, 0, 0);
			begin
				repeat (24) @(posedge clk);
				#1;
				check(ir, 1'b0, "full buffer still ready");
				check(ov, 1'b1, "full buffer not valid");
				hold = 1'b0;
			end
		join
		drain();
		// Header sequence jumps; only a flagged header reports them.
		for (int i = 0; i < 3; i++) run({rows[0]}, i < 2, 2, 0);
		drain();
		check(npk == 1, 1'b1, "packet loss count");
		// A skipped channel sequence is reported at the next segment start.
		run({rows[1]}, 1'b1, 0, 0);
		run({rows[0]}, 1'b1, 0, 1);
		drain();
		check(nsg == 1, 1'b1, "segment loss count");
		// Without a link sub-channel the low profile bit is only a profile.
		en = 1'b0;
		run({pwsh_row_t'{1, 1, 1, 8'h09, 4'h1, 2, 3'h3, 0, 1, 1}}, 1'b1, 3, 0);
		drain();
		// A reset in mid-run forgets flow and channel trackers, so jumps report nothing.
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(ir, 1'b1, "not ready after reset");
		check(ov | lp | ls, 1'b0, "output active after reset");
		check(od === '0, 1'b1, "output data not clear after reset");
		rst = 1'b0;
		npk = 0;
		nsg = 0;
		run({rows[7]}, 1'b1, 0, 3);
		drain();
		check(npk + nsg == 0, 1'b1, "loss reported after reset");
		give_verdict();
	end
endmodule
